// [common/otr_consts.vh]
/*
 Offset trim register bank constants: register indices (the byte
 address is four times the index), field layout, reset values.
 Assumes inclusion by otr design and testbench files only.
*/
`ifndef OTR_CONSTS_VH
`define OTR_CONSTS_VH
`define OTR_ADDR_W          12
`define OTR_IDX_C0_INB      12'h08C
`define OTR_IDX_C1_INA      12'h08E
`define OTR_IDX_C1_INB      12'h090
`define OTR_IDX_C2_INA      12'h092
`define OTR_IDX_CAL_CTRL    12'h0A0
`define OTR_IDX_CAL_STAT    12'h0A1
`define OTR_TRIM_MSB        11
`define OTR_TRIM_W          12
`define OTR_RSV_MSB         15
`define OTR_RSV_LSB         12
`define OTR_RSV_RST         4'h0
`define OTR_BIT_OFFSET_CAL_ENABLE      0
`define OTR_BIT_BACKGROUND_CAL_ENABLE      1
`define OTR_BIT_BACKGROUND_OFFSET_CAL_ENABLE    2
`define OTR_BIT_FG_RUN      0
`define OTR_BIT_FOREGROUND_CAL_DONE     1
`define OTR_BIT_BG_HALT     2
`define OTR_RESP_OKAY       2'b00
`define OTR_RESP_SLVERR     2'b10
`endif

// [hdl/otr_trim_reg.v]
/*
 One 16-bit offset trim register: reserved nibble plus 12-bit trim.
 Assumes the factory trim is stable while load_i is sampled.
*/
`timescale 1ns/10ps
`default_nettype none
`include "otr_consts.vh"
module otr_trim_reg
(
   // Clock and reset
   input  wire        clock_i,
   input  wire        rst_n_i,
   // Factory load
   input  wire        load_i,
   input  wire [11:0] factory_i,
   // Write port
   input  wire        wr_i,
   input  wire [15:0] wdata_i,
   input  wire [1:0]  wstrb_i,
   // Value
   output wire [15:0] value_o
);
   reg [11:0] trim_q;
   reg [3:0]  rsv_q;
   always @(posedge clock_i)
   begin
      if (!rst_n_i)
      begin
         rsv_q <= `OTR_RSV_RST;
      end
      else if (load_i)
      begin
         trim_q <= factory_i;
         rsv_q  <= `OTR_RSV_RST;
      end
      else if (wr_i)
      begin
         if (wstrb_i[0])
            trim_q[7:0] <= wdata_i[7:0];
         if (wstrb_i[1])
         begin
            trim_q[11:8] <= wdata_i[11:8];
            rsv_q        <= wdata_i[15:12];
         end
      end
   end
   assign value_o = {rsv_q, trim_q};
endmodule // otr_trim_reg
`default_nettype wire

// [hdl/otr_core_offset_trim.v]
/*
 Offset trim register bank for three sampling cores, AXI4-Lite slave.
 Assumes the factory trim pins are static; calibration status inputs
 come from logic on the same clock.
*/
// The AXI4-Lite register port is this design's own decision.
// Operation
// - Trim 0 is applied to core zero when it samples input B.
// - Trim 1 is applied to core one when it samples input A.
// - Trim 2 is applied to core one when it samples input B.
// - Trim 3 is applied to core two when it samples input A.
// - Each trim is an unsigned field in bits 11 to 0 of its register.
// - Bits 15 to 12 are read-write reserved bits that reset to zero.
// - After reset each trim holds its factory value, readable, writable.
`timescale 1ns/10ps
`default_nettype none
`include "otr_consts.vh"
module otr_core_offset_trim
(
   // Clock and reset
   input  wire        clock_i,
   input  wire        rst_n_i,
   // AXI4-Lite write address and data
   input  wire [11:0] s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output wire        s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output wire        s_axi_wready,
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   // AXI4-Lite read
   input  wire [11:0] s_axi_araddr,
   input  wire        s_axi_arvalid,
   output wire        s_axi_arready,
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   // Factory trim values
   input  wire [47:0] factory_trim_i,
   // Calibration status
   input  wire        fg_cal_running_i,
   input  wire        foreground_cal_done_i,
   input  wire        background_cal_halted_i,
   // Core input selects, 0 = input A, 1 = input B
   input  wire        core_zero_sel_b_i,
   input  wire        core_one_sel_b_i,
   input  wire        core_two_sel_b_i,
   // Applied offsets
   output reg  [11:0] core_zero_offset_o,
   output reg         core_zero_offset_vld_o,
   output reg  [11:0] core_one_offset_o,
   output reg  [11:0] core_two_offset_o,
   output reg         core_two_offset_vld_o,
   // Calibration enables
   output wire        offset_cal_enable_o,
   output wire        background_cal_enable_o,
   output wire        background_offset_cal_enable_o
);
   ////////////////////////////////////////////////////////////////////////
   // Address decode
   function [2:0] dec;
      input [11:0] a;
      begin
         case ({2'b00, a[11:2]})
            `OTR_IDX_C0_INB:   dec = 3'd0;
            `OTR_IDX_C1_INA:   dec = 3'd1;
            `OTR_IDX_C1_INB:   dec = 3'd2;
            `OTR_IDX_C2_INA:   dec = 3'd3;
            `OTR_IDX_CAL_CTRL: dec = 3'd4;
            `OTR_IDX_CAL_STAT: dec = 3'd5;
            default:           dec = 3'd7;
         endcase
         // Misaligned byte addresses hit no register
         if (a[1:0] != 2'b00)
            dec = 3'd7;
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Write channel capture
   reg        aw_full_q;
   reg [11:0] aw_addr_q;
   reg        w_full_q;
   reg [31:0] w_data_q;
   reg [3:0]  w_strb_q;
   reg        load_q;
   reg [2:0]  cal_ctrl_q;
   wire       wr_go;
   wire [2:0] wsel;
   wire [63:0] trim_all;

   assign s_axi_awready = !aw_full_q && !s_axi_bvalid;
   assign s_axi_wready  = !w_full_q && !s_axi_bvalid;
   assign wr_go = aw_full_q && w_full_q && !s_axi_bvalid;
   assign wsel  = dec(aw_addr_q);

   always @(posedge clock_i)
   begin
      if (!rst_n_i)
      begin
         aw_full_q    <= 1'b0;
         aw_addr_q    <= 12'h000;
         w_full_q     <= 1'b0;
         w_data_q     <= 32'h0000_0000;
         w_strb_q     <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `OTR_RESP_OKAY;
         cal_ctrl_q   <= 3'b000;
         load_q       <= 1'b1;
      end
      else
      begin
         load_q <= 1'b0;
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_full_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_full_q <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
         end
         if (wr_go)
         begin
            aw_full_q    <= 1'b0;
            w_full_q     <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (wsel == 3'd7 || wsel == 3'd5) ?
                            `OTR_RESP_SLVERR : `OTR_RESP_OKAY;
            if (wsel == 3'd4 && w_strb_q[0])
               cal_ctrl_q <= w_data_q[2:0];
         end
         else if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end

   assign offset_cal_enable_o            = cal_ctrl_q[`OTR_BIT_OFFSET_CAL_ENABLE];
   assign background_cal_enable_o        = cal_ctrl_q[`OTR_BIT_BACKGROUND_CAL_ENABLE];
   assign background_offset_cal_enable_o = cal_ctrl_q[`OTR_BIT_BACKGROUND_OFFSET_CAL_ENABLE];

   ////////////////////////////////////////////////////////////////////////
   // Trim registers
   genvar g;
   generate
      for (g = 0; g < 4; g = g + 1)
      begin : g_trim
         otr_trim_reg u_reg
         (
            .clock_i   (clock_i),
            .rst_n_i   (rst_n_i),
            .load_i    (load_q),
            .factory_i (factory_trim_i[g*12 +: 12]),
            .wr_i      (wr_go && wsel == g),
            .wdata_i   (w_data_q[15:0]),
            .wstrb_i   (w_strb_q[1:0]),
            .value_o   (trim_all[g*16 +: 16])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // Read channel
   reg [31:0] rd_mux;
   assign s_axi_arready = !s_axi_rvalid;
   always @*
   begin
      rd_mux = 32'h0000_0000;
      case (dec(s_axi_araddr))
         3'd0: rd_mux[15:0] = trim_all[15:0];
         3'd1: rd_mux[15:0] = trim_all[31:16];
         3'd2: rd_mux[15:0] = trim_all[47:32];
         3'd3: rd_mux[15:0] = trim_all[63:48];
         3'd4: rd_mux[2:0]  = cal_ctrl_q;
         3'd5: rd_mux[2:0]  = {background_cal_halted_i,
                               foreground_cal_done_i, fg_cal_running_i};
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   always @(posedge clock_i)
   begin
      if (!rst_n_i)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= `OTR_RESP_OKAY;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= rd_mux;
         s_axi_rresp  <= (dec(s_axi_araddr) == 3'd7) ?
                         `OTR_RESP_SLVERR : `OTR_RESP_OKAY;
      end
      else if (s_axi_rvalid && s_axi_rready)
         s_axi_rvalid <= 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////
   // Offset application per core and input
   always @(posedge clock_i)
   begin
      if (!rst_n_i)
      begin
         core_zero_offset_o     <= 12'h000;
         core_zero_offset_vld_o <= 1'b0;
         core_one_offset_o      <= 12'h000;
         core_two_offset_o      <= 12'h000;
         core_two_offset_vld_o  <= 1'b0;
      end
      else
      begin
         core_zero_offset_vld_o <= core_zero_sel_b_i;
         if (core_zero_sel_b_i)
            core_zero_offset_o <= trim_all[11:0];
         if (core_one_sel_b_i)
            core_one_offset_o <= trim_all[43:32];
         else
            core_one_offset_o <= trim_all[27:16];
         core_two_offset_vld_o <= !core_two_sel_b_i;
         if (!core_two_sel_b_i)
            core_two_offset_o <= trim_all[59:48];
      end
   end
endmodule // otr_core_offset_trim
`default_nettype wire

// [dv/otr_trim_asserts.sv]
/* Port checker for the offset trim bank.
   Bound to otr_core_offset_trim; one clock, sync reset. */
`timescale 1ns/10ps
`default_nettype none
module otr_trim_asserts
(
   // Clock and reset
   input wire logic        clock_i,
   input wire logic        rst_n_i,
   // Bus handshakes
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic        s_axi_rvalid,
   // Cores
   input wire logic        core_zero_sel_b_i,
   input wire logic        core_one_sel_b_i,
   input wire logic        core_two_sel_b_i,
   input wire logic [11:0] core_zero_offset_o,
   input wire logic        core_zero_offset_vld_o,
   input wire logic [11:0] core_two_offset_o,
   input wire logic        core_two_offset_vld_o
);
   default clocking @(posedge clock_i); endclocking
   default disable iff (!rst_n_i);
   vld0_on_a:
      assert property (core_zero_sel_b_i |=> core_zero_offset_vld_o)
      else $error("core zero valid missing");
   vld0_off_a:
      assert property (!core_zero_sel_b_i |=> !core_zero_offset_vld_o)
      else $error("core zero valid off input B");
   off0_hold_a:
      assert property (!core_zero_sel_b_i |=> $stable(core_zero_offset_o))
      else $error("core zero offset moved off input B");
   vld2_on_a:
      assert property (!core_two_sel_b_i |=> core_two_offset_vld_o)
      else $error("core two valid missing");
   off2_hold_a:
      assert property (core_two_sel_b_i |=> $stable(core_two_offset_o))
      else $error("core two offset moved off input A");
   rd_upper_a:
      assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
      else $error("read data upper half not zero");
   wr_resp_a:
      assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
         && s_axi_wready |-> ##[1:2] s_axi_bvalid)
      else $error("write response missing");
   rd_resp_a:
      assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read response missing");
   cover property (s_axi_bvalid);
   cover property (s_axi_rvalid);
   cover property (core_one_sel_b_i && core_zero_sel_b_i);
endmodule // otr_trim_asserts
bind otr_core_offset_trim otr_trim_asserts u_otr_trim_asserts
(
   .clock_i, .rst_n_i, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
   .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready,
   .s_axi_rdata, .s_axi_rvalid, .core_zero_sel_b_i, .core_one_sel_b_i,
   .core_two_sel_b_i, .core_zero_offset_o, .core_zero_offset_vld_o,
   .core_two_offset_o, .core_two_offset_vld_o
);
`default_nettype wire

// [dv/otr_core_offset_trim_tb_top.sv]
/* Testbench for the offset trim bank.
   Acts as bus master and core sequencer itself. */
`timescale 1ns/10ps
`default_nettype none
`include "otr_consts.vh"
module otr_core_offset_trim_tb_top;
   localparam logic [47:0] FT = 48'h1234_5678_9abc;
   logic clock_i = 1'b0, rst_n_i = 1'b0;
   logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
   logic [31:0] s_axi_wdata = '0, d;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic s_axi_arvalid = 0, s_axi_rready = 0, fg_cal_running_i = 0;
   logic foreground_cal_done_i = 1, background_cal_halted_i = 1;
   logic core_zero_sel_b_i = 0, core_one_sel_b_i = 0, core_two_sel_b_i = 1;
   wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   wire logic s_axi_rvalid, core_zero_offset_vld_o, core_two_offset_vld_o;
   wire logic [1:0] s_axi_bresp, s_axi_rresp;
   wire logic [31:0] s_axi_rdata;
   wire logic [11:0] core_zero_offset_o, core_one_offset_o, core_two_offset_o;
   wire logic offset_cal_enable_o, background_cal_enable_o;
   wire logic background_offset_cal_enable_o;
   logic [15:0] tv [4];
   logic [1:0] r;
   int err_total = 0, check_count = 0, cyc = 0;
   otr_core_offset_trim u_otr_core_offset_trim
   (
      .clock_i, .rst_n_i, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .factory_trim_i(FT), .fg_cal_running_i,
      .foreground_cal_done_i, .background_cal_halted_i, .core_zero_sel_b_i,
      .core_one_sel_b_i, .core_two_sel_b_i, .core_zero_offset_o,
      .core_zero_offset_vld_o, .core_one_offset_o, .core_two_offset_o,
      .core_two_offset_vld_o, .offset_cal_enable_o,
      .background_cal_enable_o, .background_offset_cal_enable_o
   );
   always #50 clock_i = ~clock_i;
   function automatic logic [11:0] ad(input int i);
      logic [11:0] x;
      begin
         x = (i == 0) ? `OTR_IDX_C0_INB : (i == 1) ? `OTR_IDX_C1_INA :
             (i == 2) ? `OTR_IDX_C1_INB : (i == 3) ? `OTR_IDX_C2_INA :
             (i == 4) ? `OTR_IDX_CAL_CTRL : `OTR_IDX_CAL_STAT;
         ad = {x[9:0], 2'b00};
      end
   endfunction
   task end_sim;
      begin
         if (err_total == 0 && check_count > 0)
            $display("Run complete: PASS");
         else
            $display("Run complete: FAIL");
         $finish;
      end
   endtask
   task chk(input logic [31:0] g, input logic [31:0] e);
      begin
         check_count++;
         if (g !== e)
         begin
            err_total++;
            $display("[FAIL] %0t got %h expected %h", $time, g, e);
         end
      end
   endtask
   task axw(input logic [11:0] a, input logic [31:0] w, input logic [3:0] s);
      begin
         s_axi_awaddr <= a;
         s_axi_wdata <= w;
         s_axi_wstrb <= s;
         s_axi_awvalid <= 1'b1;
         s_axi_wvalid <= 1'b1;
         s_axi_bready <= 1'b1;
         do
         begin
            @(posedge clock_i);
            if (s_axi_awready)
               s_axi_awvalid <= 1'b0;
            if (s_axi_wready)
               s_axi_wvalid <= 1'b0;
         end
         while (!s_axi_bvalid);
         r = s_axi_bresp;
         s_axi_bready <= 1'b0;
         @(posedge clock_i);
      end
   endtask
   task axr(input logic [11:0] a);
      begin
         s_axi_araddr <= a;
         s_axi_arvalid <= 1'b1;
         s_axi_rready <= 1'b1;
         do
         begin
            @(posedge clock_i);
            if (s_axi_arready)
               s_axi_arvalid <= 1'b0;
         end
         while (!s_axi_rvalid);
         d = s_axi_rdata;
         r = s_axi_rresp;
         s_axi_rready <= 1'b0;
         @(posedge clock_i);
      end
   endtask
   task rdchk(input int i);
      begin
         axr(ad(i));
         chk({30'h0, r}, {30'h0, `OTR_RESP_OKAY});
         chk(d, {16'h0, tv[i]});
      end
   endtask
   task t_write_iso;
      begin
         for (int i = 0; i < 4; i++)
         begin
            tv[i] = 16'h5a30 + 16'h1111 * 16'(i);
            axw(ad(i), {16'h0, tv[i]}, 4'hf);
            for (int j = 0; j < 4; j++)
               rdchk(j);
         end
         tv[1][7:0] = 8'h55;
         axw(ad(1), 32'h0000_aa55, 4'b0001);
         rdchk(1);
      end
   endtask
   task t_apply;
      begin
         core_zero_sel_b_i <= 1'b1;
         core_two_sel_b_i <= 1'b0;
         repeat (2) @(posedge clock_i);
         chk({20'h0, core_zero_offset_o}, {20'h0, tv[0][11:0]});
         chk({20'h0, core_one_offset_o}, {20'h0, tv[1][11:0]});
         chk({20'h0, core_two_offset_o}, {20'h0, tv[3][11:0]});
         core_one_sel_b_i <= 1'b1;
         repeat (2) @(posedge clock_i);
         chk({20'h0, core_one_offset_o}, {20'h0, tv[2][11:0]});
      end
   endtask
   task t_unmapped;
      begin
         axw(12'hffc, 32'h0000_0fff, 4'hf);
         chk({30'h0, r}, {30'h0, `OTR_RESP_SLVERR});
         axr(12'hffc);
         chk({d[29:0], r}, {30'h0, `OTR_RESP_SLVERR});
         rdchk(0);
      end
   endtask
   task t_cal;
      begin
         axw(ad(4), 32'h0000_0005, 4'hf);
         chk({30'h0, r}, {30'h0, `OTR_RESP_OKAY});
         chk({29'h0, background_offset_cal_enable_o, background_cal_enable_o,
            offset_cal_enable_o}, 32'h0000_0005);
         axr(ad(4));
         chk(d, 32'h0000_0005);
         axw(ad(5), 32'h0000_0007, 4'hf);
         chk({30'h0, r}, {30'h0, `OTR_RESP_SLVERR});
         axr(ad(5));
         chk(d, 32'h0000_0006);
      end
   endtask
   task t_reset;
      begin
         rst_n_i <= 1'b0;
         repeat (2) @(posedge clock_i);
         rst_n_i <= 1'b1;
         repeat (2) @(posedge clock_i);
         chk({29'h0, background_offset_cal_enable_o, background_cal_enable_o,
            offset_cal_enable_o}, 32'h0000_0000);
         for (int i = 0; i < 4; i++)
         begin
            tv[i] = {4'h0, FT[i * 12 +: 12]};
            rdchk(i);
         end
      end
   endtask
   always @(posedge clock_i)
   begin
      cyc++;
      if (cyc == 4000)
      begin
         err_total++;
         end_sim;
      end
   end
   initial
   begin
      for (int i = 0; i < 4; i++)
         tv[i] = {4'h0, FT[i * 12 +: 12]};
      repeat (8) @(posedge clock_i);
      rst_n_i <= 1'b1;
      repeat (2) @(posedge clock_i);
      for (int i = 0; i < 4; i++)
         rdchk(i);
      t_write_iso;
      t_apply;
      t_unmapped;
      t_cal;
      t_reset;
      end_sim;
   end
endmodule // otr_core_offset_trim_tb_top
`default_nettype wire
